// File: bench/ospt_clk_cfg_sva.sv
/* port checker for ospt_clk_cfg, bound below.
   assumes one mclk domain with synchronous srst */
`timescale 1ns/1ps
module ospt_clk_cfg_sva (
  // clock, reset, enable
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        ce,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // oscillator and PLL side
  input wire logic [1:0]  osc_input_select,
  input wire logic        internal_osc_disable,
  input wire logic        main_osc_disable,
  input wire logic        sysclk_bypass,
  input wire logic [1:0]  pll_output_divide,
  input wire logic [8:0]  pll_feedback,
  input wire logic [4:0]  pll_reference
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  wire        wcfg = ce && reg_wr && reg_addr == 12'h060;
  wire        wtr  = ce && reg_wr && reg_addr == 12'h064;
  wire [15:0] tr   = {pll_output_divide, pll_feedback, pll_reference};
  AST_OD_LEGAL: assert property (pll_output_divide != 2'h3)
    else $error("reserved output divide driven");
  AST_SEL_LEGAL: assert property (osc_input_select != 2'h3)
    else $error("reserved source selected");
  AST_WR_SEL: assert property (wcfg && reg_wdata[5:4] != 2'h3 |=>
    osc_input_select == $past(reg_wdata[5:4])) else $error("source not written");
  AST_WR_DIS: assert property (wcfg |=>
    {internal_osc_disable, main_osc_disable} == $past(reg_wdata[1:0]))
    else $error("disables not written");
  AST_RD_CFG: assert property (ce && reg_rd && reg_addr == 12'h060 |=>
    {reg_rdata[31:12], reg_rdata[10], reg_rdata[3:2]} == 23'h0)
    else $error("reserved config bits not zero");
  AST_RD_TR: assert property (ce && reg_rd && reg_addr == 12'h064 |=>
    reg_rdata == {16'h0, $past(tr)}) else $error("translation readback differs");
  AST_CRYSTAL_FREQ_CODE: assert property (wcfg ##1 ce |=>
    tr == ospt_pkg::TRANS_LUT[$past(reg_wdata[9:6], 2)])
    else $error("PLL pins do not follow crystal code");
  AST_RO: assert property (wtr && $past(ce) && !$past(wcfg) |=> $stable(tr))
    else $error("translation changed by a write");
  COV_WCFG: cover property (wcfg);
  COV_WTR: cover property (wtr);
  COV_RSEL: cover property (wcfg && reg_wdata[5:4] == 2'h3);
endmodule // ospt_clk_cfg_sva

bind ospt_clk_cfg ospt_clk_cfg_sva i_ospt_clk_cfg_sva (.mclk, .srst, .ce, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .osc_input_select, .internal_osc_disable,
  .main_osc_disable, .sysclk_bypass, .pll_output_divide, .pll_feedback, .pll_reference);

// File: bench/ospt_pll_model.sv
/* PLL and oscillator stand-in giving the PLL output rate in kHz.
   assumes the block's level outputs; rates are plain defaults */
`timescale 1ns/1ps
module ospt_pll_model #(
  parameter int XK = 6000,
  parameter int IK = 12000
) (
  // controls from the block
  input wire logic [1:0] osc_input_select,
  input wire logic       internal_osc_disable,
  input wire logic       main_osc_disable,
  input wire logic [1:0] pll_output_divide,
  input wire logic [8:0] pll_feedback,
  input wire logic [4:0] pll_reference,
  // rate at the PLL output
  output logic [31:0]    pll_khz
);
  // four-state so an unknown pin shows up instead of reading as zero
  logic [31:0] osc_khz;
  // a stopped oscillator feeds nothing, so the rate drops to zero
  assign osc_khz = osc_input_select == 2'h0 ? (main_osc_disable ? 0 : XK) :
                   internal_osc_disable ? 0 :
                   osc_input_select == 2'h1 ? IK : IK / 4;
  assign pll_khz = osc_khz * pll_feedback / (pll_reference + 1) >> pll_output_divide;
endmodule // ospt_pll_model

// File: bench/tb_ospt_clk_cfg.sv
/* self-checking bench for ospt_clk_cfg with the PLL stand-in.
   assumes config at 0x060, translation at 0x064, package lookup */
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_ospt_clk_cfg;
  logic        mclk = 1'b0, srst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d, e;
  logic [1:0]  osc_input_select, pll_output_divide, s, old_s;
  logic        internal_osc_disable, main_osc_disable, sysclk_bypass;
  logic [8:0]  pll_feedback;
  logic [4:0]  pll_reference;
  logic [3:0]  c;
  logic [31:0] pll_khz;
  logic [4:0]  pins;
  int          bad_count = 0, cmp_count = 0, cyc = 0;
  ospt_pkg::ospt_trans_t t;
  ospt_clk_cfg i_ospt_clk_cfg (.mclk, .srst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .osc_input_select, .internal_osc_disable, .main_osc_disable, .sysclk_bypass,
    .pll_output_divide, .pll_feedback, .pll_reference);
  ospt_pll_model i_ospt_pll_model (.osc_input_select, .internal_osc_disable,
    .main_osc_disable, .pll_output_divide, .pll_feedback, .pll_reference, .pll_khz);
  always #2.5 mclk = ~mclk;
  // expected PLL rate from config bits and table entry, model defaults
  function automatic int exp_rate(logic [31:0] g, ospt_pkg::ospt_trans_t x);
    int o;
    o = g[5:4] == 2'h0 ? (g[0] ? 0 : 6000) : g[1] ? 0 : g[5:4] == 2'h1 ? 12000 : 3000;
    return o * x.f / (x.r + 1) >> x.od;
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // a hang costs a mismatch; the run needs well under 2000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(2));
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    rd(12'h060, d);
    `CHK("cfg reset", 32'h0000_0ad1, d)
    rd(12'h064, d);
    `CHK("trans reset", {16'h0, ospt_pkg::TRANS_LUT[4'hb]}, d)
    old_s = 2'h1;
    for (int i = 0; i < 40; i++) begin
      c = (i < 16) ? i[3:0] : 4'($urandom);
      s = 2'($urandom);
      d = $urandom;
      d[9:6] = c;
      // with bypass clear, software never feeds the undivided internal oscillator to the PLL
      if (!d[11] && (s == 2'h1 || (s == 2'h3 && old_s == 2'h1))) s = 2'h2;
      d[5:4] = s;
      wr(12'h060, d);
      if (s != 2'h3) old_s = s;
      e = {20'h0, d[11], 1'b0, c, old_s, 2'h0, d[1:0]};
      t = ospt_pkg::TRANS_LUT[c];
      rd(12'h060, d);
      `CHK("cfg", e, d)
      pins = {sysclk_bypass, osc_input_select, internal_osc_disable, main_osc_disable};
      `CHK("osc pins", {e[11], e[5:4], e[1:0]}, pins)
      rd(12'h064, d);
      `CHK("trans", {16'h0, t}, d)
      `CHK("pll pins", t, {pll_output_divide, pll_feedback, pll_reference})
      `CHK("pll rate", exp_rate(e, t), pll_khz)
      wr(12'h064, $urandom);
      wr(12'h068, $urandom);
      rd(12'h068, d);
      `CHK("unmapped", 32'h0, d)
      rd(12'h064, d);
      `CHK("trans ro", {16'h0, t}, d)
    end
    // clock enable low: a write in that window must not land
    rd(12'h060, e);
    @(posedge mclk);
    ce <= 1'b0;
    wr(12'h060, ~e);
    @(posedge mclk);
    ce <= 1'b1;
    rd(12'h060, d);
    `CHK("ce freeze", e, d)
    // second reset from a non-default state
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    rd(12'h060, d);
    `CHK("cfg re-reset", 32'h0000_0ad1, d)
    rd(12'h064, d);
    `CHK("trans re-reset", {16'h0, ospt_pkg::TRANS_LUT[4'hb]}, d)
    tally_and_finish();
  end
endmodule // tb_ospt_clk_cfg

// File: src/ospt_clk_cfg.sv
/*
  Run-mode clock configuration: oscillator source select, oscillator
  disables, PLL bypass select and the read-only crystal translation
  register that drives the PLL multiplier, reference and output divide.
  Assumes a single-cycle register port on mclk and an analog PLL and
  oscillator set that take these levels directly.
*/
// Overview of operation
// - a two-bit oscillator source field at bits 5:4 resets to internal and picks main, internal or internal/4.
// - bit 1 disables the internal oscillator when set and resets to zero.
// - bit 0 disables the main oscillator, resets to one, and a zero enables it.
// - reserved bits read zero and software keeps them across read-modify-write.
// - the translation register is loaded at reset and refreshed whenever the crystal code changes.
// - the PLL runs at oscillator times feedback over reference plus one.
// - the output divide at bits 15:14 goes to the PLL as divide by one, two or four.
// - the nine-bit feedback at bits 13:5 drives the PLL multiplier input.
// - the five-bit reference at bits 4:0 drives the PLL reference input.
// - the translation register at 0x064 is read-only and follows the crystal code.
// - a four-bit crystal code at bits 9:6 resets to 0xb and steers the translation lookup.
// - with bypass set the system clock is the oscillator source, else the divided PLL output.
`timescale 1ns/1ps
module ospt_clk_cfg (
  // clock, reset, enable
  input  wire logic                        mclk,
  input  wire logic                        srst,
  input  wire logic                        ce,
  // register port
  input  wire logic [ospt_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [ospt_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [ospt_pkg::DATA_W-1:0] reg_rdata,
  // oscillator controls
  output logic      [1:0]                  osc_input_select,
  output logic                             internal_osc_disable,
  output logic                             main_osc_disable,
  output logic                             sysclk_bypass,
  // PLL inputs
  output logic      [1:0]                  pll_output_divide,
  output logic      [8:0]                  pll_feedback,
  output logic      [4:0]                  pll_reference
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [1:0]                  osc_sel_r;
  logic [1:0]                  osc_sel_nxt;
  logic                        internal_osc_dis_r;
  logic                        mosc_dis_r;
  logic                        bypass_r;
  logic [3:0]                  crystal_freq_code_r;
  ospt_pkg::ospt_trans_t       trans_r;
  ospt_pkg::ospt_trans_t       trans_nxt;
  logic [ospt_pkg::DATA_W-1:0] rdata_r;
  logic [ospt_pkg::DATA_W-1:0] rdata_nxt;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire logic hit_cfg   = (reg_addr == ospt_pkg::RUN_CFG_OFS);
  wire logic hit_trans = (reg_addr == ospt_pkg::TRANS_OFS);
  wire logic wr_cfg    = reg_wr & hit_cfg;
  // writes aimed at the translation register fall through untaken
  wire logic [1:0] wr_osc = reg_wdata[ospt_pkg::OSC_SEL_MSB:ospt_pkg::OSC_SEL_LSB];

  // a reserved source code keeps the previous selection
  assign osc_sel_nxt = (wr_osc == ospt_pkg::OSPT_SRC_RSVD) ? osc_sel_r : wr_osc;

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      osc_sel_r  <= ospt_pkg::OSC_SEL_RST;
      internal_osc_dis_r <= ospt_pkg::INTERNAL_OSC_DIS_RST;
      mosc_dis_r <= ospt_pkg::MOSC_DIS_RST;
      bypass_r   <= ospt_pkg::BYPASS_RST;
      crystal_freq_code_r     <= ospt_pkg::CRYSTAL_FREQ_CODE_RST;
    end else if (ce && wr_cfg) begin
      osc_sel_r  <= osc_sel_nxt;
      internal_osc_dis_r <= reg_wdata[ospt_pkg::INTERNAL_OSC_DIS_BIT];
      mosc_dis_r <= reg_wdata[ospt_pkg::MOSC_DIS_BIT];
      bypass_r   <= reg_wdata[ospt_pkg::BYPASS_BIT];
      crystal_freq_code_r     <= reg_wdata[ospt_pkg::CRYSTAL_FREQ_CODE_MSB:ospt_pkg::CRYSTAL_FREQ_CODE_LSB];
    end
  end

  // ---------------------------------------------------------------
  // crystal translation
  // ---------------------------------------------------------------
  ospt_crystal_freq_code_lut u_lut (
    .crystal_freq_code_code (crystal_freq_code_r),
    .trans     (trans_nxt)
  );

  // tracking every cycle with ce high covers any change of code at the next edge with ce high
  always_ff @(posedge mclk) begin
    if (srst) begin
      trans_r <= ospt_pkg::TRANS_RST;
    end else if (ce) begin
      trans_r <= trans_nxt;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  wire logic [ospt_pkg::DATA_W-1:0] cfg_word;
  wire logic [ospt_pkg::DATA_W-1:0] trans_word;

  // every unlisted bit, reserved ones included, reads zero
  assign cfg_word = {
    20'h00000,
    bypass_r,
    1'h0,
    crystal_freq_code_r,
    osc_sel_r,
    2'h0,
    internal_osc_dis_r,
    mosc_dis_r
  };
  assign trans_word = {16'h0000, trans_r};

  assign rdata_nxt = !reg_rd   ? '0 :
                     hit_cfg   ? cfg_word :
                     hit_trans ? trans_word : '0;

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_r <= '0;
    end else if (ce) begin
      rdata_r <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata            = rdata_r;
  assign osc_input_select     = osc_sel_r;
  assign internal_osc_disable = internal_osc_dis_r;
  assign main_osc_disable     = mosc_dis_r;
  // only a select: the glitch-free clock switch lives with the clock tree
  assign sysclk_bypass        = bypass_r;
  // the PLL forms osc * f / (r + 1) from these levels
  assign pll_output_divide    = trans_r.od;
  assign pll_feedback         = trans_r.f;
  assign pll_reference        = trans_r.r;

endmodule // ospt_clk_cfg

// File: src/ospt_crystal_freq_code_lut.sv
/*
  Combinational crystal-code to PLL setting lookup.
  Assumes the caller registers the result.
*/
`timescale 1ns/1ps
module ospt_crystal_freq_code_lut (
  // crystal code in
  input  wire logic [3:0]           crystal_freq_code_code,
  // PLL settings out
  output ospt_pkg::ospt_trans_t     trans
);

  ospt_pkg::ospt_trans_t raw;

  assign raw   = ospt_pkg::TRANS_LUT[crystal_freq_code_code];
  // the reserved divide code never leaves this module
  assign trans = (raw.od == ospt_pkg::OD_RSVD) ? ospt_pkg::TRANS_SAFE : raw;

endmodule // ospt_crystal_freq_code_lut

// File: src/ospt_pkg.sv
/*
  Constants, field layouts and types for the run-mode oscillator selector
  and crystal-to-PLL translation block.
  Assumes a 32-bit register port with byte offsets in a 12-bit address.
*/
package ospt_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam logic [11:0] RUN_CFG_OFS   = 12'h060;
  localparam logic [11:0] TRANS_OFS     = 12'h064;

  // ---------------------------------------------------------------
  // run clock configuration fields
  // ---------------------------------------------------------------
  localparam int MOSC_DIS_BIT   = 0;
  localparam int INTERNAL_OSC_DIS_BIT   = 1;
  localparam int OSC_SEL_LSB    = 4;
  localparam int OSC_SEL_MSB    = 5;
  localparam int CRYSTAL_FREQ_CODE_LSB       = 6;
  localparam int CRYSTAL_FREQ_CODE_MSB       = 9;
  localparam int BYPASS_BIT     = 11;

  localparam logic       MOSC_DIS_RST = 1'h1;
  localparam logic       INTERNAL_OSC_DIS_RST = 1'h0;
  localparam logic       BYPASS_RST   = 1'h1;
  localparam logic [3:0] CRYSTAL_FREQ_CODE_RST     = 4'hb;

  typedef enum logic [1:0] {
    OSPT_SRC_MAIN     = 2'h0,
    OSPT_SRC_INT      = 2'h1,
    OSPT_SRC_INT_DIV4 = 2'h2,
    OSPT_SRC_RSVD     = 2'h3
  } ospt_osc_src_t;

  localparam ospt_osc_src_t OSC_SEL_RST = OSPT_SRC_INT;

  // ---------------------------------------------------------------
  // translation fields
  // ---------------------------------------------------------------
  localparam int TR_R_LSB  = 0;
  localparam int TR_R_MSB  = 4;
  localparam int TR_F_LSB  = 5;
  localparam int TR_F_MSB  = 13;
  localparam int TR_OD_LSB = 14;
  localparam int TR_OD_MSB = 15;
  localparam int TR_W      = 16;

  // output divide encodings
  localparam logic [1:0] OD_DIV1 = 2'h0;
  localparam logic [1:0] OD_DIV2 = 2'h1;
  localparam logic [1:0] OD_DIV4 = 2'h2;
  localparam logic [1:0] OD_RSVD = 2'h3;

  typedef struct packed {
    logic [1:0] od;
    logic [8:0] f;
    logic [4:0] r;
  } ospt_trans_t;

  // safe default for codes that cannot feed the PLL: zero feedback, so the PLL output is zero
  localparam ospt_trans_t TRANS_SAFE = '{od: OD_DIV1, f: 9'h000, r: 5'h00};

  // every usable code targets a 400 MHz VCO, halved at the output
  localparam ospt_trans_t TRANS_LUT [16] = '{
    TRANS_SAFE, TRANS_SAFE, TRANS_SAFE, TRANS_SAFE,
    '{od: OD_DIV2, f: 9'h1bf, r: 5'h03},
    '{od: OD_DIV2, f: 9'h1b2, r: 5'h03},
    '{od: OD_DIV2, f: 9'h190, r: 5'h03},
    '{od: OD_DIV2, f: 9'h187, r: 5'h03},
    '{od: OD_DIV2, f: 9'h197, r: 5'h04},
    '{od: OD_DIV2, f: 9'h190, r: 5'h04},
    '{od: OD_DIV2, f: 9'h187, r: 5'h04},
    '{od: OD_DIV2, f: 9'h190, r: 5'h05},
    '{od: OD_DIV2, f: 9'h187, r: 5'h05},
    '{od: OD_DIV2, f: 9'h17c, r: 5'h06},
    '{od: OD_DIV2, f: 9'h190, r: 5'h07},
    '{od: OD_DIV2, f: 9'h187, r: 5'h07}
  };

  localparam ospt_trans_t TRANS_RST = TRANS_LUT[CRYSTAL_FREQ_CODE_RST];

endpackage
